// *** design/nobe_core.sv ***
// Execution unit for negate, idle, OR and block-output instructions
`timescale 1ns/100ps
module nobe_core #(
  parameter int FIFO_DEPTH = nobe_pkg::IO_FIFO_DEPTH
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RST,
  input  wire logic                LOAD_EN,
  input  wire nobe_pkg::nobe_regs_t LOAD_REGS,
  output logic                     MEM_REQ,
  output logic [15:0]              MEM_ADDR,
  input  wire logic                MEM_ACK,
  input  wire logic [7:0]          MEM_RDATA,
  output logic                     IO_VALID,
  input  wire logic                IO_READY,
  output nobe_pkg::nobe_io_t       IO_WORD,
  input  wire logic                INT_REQ,
  output logic                     INT_ACK,
  output logic                     INSTR_BOUNDARY,
  output nobe_pkg::nobe_regs_t     REGS
);
  import nobe_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_bad
    $error("FIFO_DEPTH must be at least two");
  end

  ////////////////////////////////////////////////////////////////////
  // State

  nobe_state_t st_r;
  nobe_state_t st_nxt;
  nobe_pfx_t   pfx_r;
  nobe_pfx_t   pfx_nxt;
  nobe_regs_t  rf_r;
  nobe_regs_t  rf_nxt;
  logic [7:0]  ir_r;
  logic [7:0]  ir_nxt;
  logic [7:0]  hold_r;
  logic [7:0]  hold_nxt;
  logic [15:0] ea_r;
  logic [15:0] ea_nxt;
  logic        fifo_in_ready;
  nobe_io_t    io_push;

  ////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  function automatic logic [7:0] reg_pick(nobe_regs_t r, logic [2:0] s);
    case (s)
      SRC_B:   reg_pick = r.b;
      SRC_C:   reg_pick = r.c;
      SRC_D:   reg_pick = r.d;
      SRC_E:   reg_pick = r.e;
      SRC_H:   reg_pick = r.h;
      SRC_L:   reg_pick = r.l;
      default: reg_pick = r.a;
    endcase
  endfunction

  function automatic logic [7:0] tc_flags(logic [7:0] f, logic [7:0] a,
                                          logic [7:0] r);
    tc_flags = f;
    tc_flags[FLG_S] = r[7];
    tc_flags[FLG_Z] = r == ZERO_BYTE;
    tc_flags[FLG_H] = a[3:0] != 4'h0;
    tc_flags[FLG_PV] = a == SIGN_BYTE;
    tc_flags[FLG_N] = 1'b1;
    tc_flags[FLG_C] = a != ZERO_BYTE;
  endfunction

  function automatic logic [7:0] or_flags(logic [7:0] f, logic [7:0] r);
    or_flags = f;
    or_flags[FLG_S] = r[7];
    or_flags[FLG_Z] = r == ZERO_BYTE;
    or_flags[FLG_H] = 1'b0;
    or_flags[FLG_PV] = ~^r;
    or_flags[FLG_N] = 1'b0;
    or_flags[FLG_C] = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decode

  wire logic        pfx_ext   = pfx_r == PFX_EXT;
  wire logic        pfx_index = pfx_r == PFX_FIRST || pfx_r == PFX_SECOND;
  wire logic [15:0] ptr_pair  = {rf_r.h, rf_r.l};
  wire logic [15:0] base      = (pfx_r == PFX_SECOND) ? rf_r.second_offset_base
                                                      : rf_r.first_offset_base;
  wire logic [15:0] disp      = {{8{MEM_RDATA[7]}}, MEM_RDATA};
  wire logic [15:0] pc_inc    = rf_r.pc + PTR_STEP;

  // After the extended prefix every byte is an opcode, never a prefix
  wire nobe_pfx_t new_pfx = pfx_ext                    ? PFX_NONE   :
                            (ir_r == PFX_EXT_BYTE)    ? PFX_EXT    :
                            (ir_r == PFX_FIRST_BYTE)  ? PFX_FIRST  :
                            (ir_r == PFX_SECOND_BYTE) ? PFX_SECOND :
                                                        PFX_NONE;

  wire logic is_tc = pfx_ext && ir_r == TWOS_COMPLEMENT_OP;
  wire logic is_blk = pfx_ext && (ir_r == BLOCK_OUT_DOWN_OP ||
                                  ir_r == BLOCK_OUT_UP_OP);
  wire logic blk_dn = ir_r == BLOCK_OUT_DOWN_OP;
  wire logic is_or     = !pfx_ext && ir_r[7:3] == OR_GROUP;
  wire logic is_or_mem = is_or && ir_r[2:0] == SRC_MEM;
  wire logic is_or_imm = !pfx_ext && ir_r == OR_IMM_OP;

  wire logic [7:0] reg_val = reg_pick(rf_r, ir_r[2:0]);
  wire logic [7:0] tc_res  = ZERO_BYTE - rf_r.a;
  wire logic [7:0] or_src  = (st_r == ST_DECODE) ? reg_val : MEM_RDATA;
  wire logic [7:0] or_res  = rf_r.a | or_src;
  wire logic [7:0] b_dec   = rf_r.b - BYTE_ONE;
  wire logic [15:0] ptr_moved = blk_dn ? ptr_pair - PTR_STEP : ptr_pair + PTR_STEP;

  wire logic push_ok = st_r == ST_IOWR && fifo_in_ready;

  ////////////////////////////////////////////////////////////////////
  // Bus side

  // Loading the register file takes priority over the next fetch
  assign MEM_REQ = (st_r == ST_FETCH && !LOAD_EN) || st_r == ST_DISP ||
                   st_r == ST_IMM || st_r == ST_MEMRD;
  assign MEM_ADDR = (st_r == ST_MEMRD) ? ea_r : rf_r.pc;

  // port index on low byte, count on high byte
  assign io_push.addr = {rf_r.b, rf_r.c};
  // held byte goes out as the write data
  assign io_push.data = hold_r;

  assign INT_ACK = push_ok && rf_r.b != ZERO_BYTE && INT_REQ;
  assign INSTR_BOUNDARY = st_r == ST_FETCH && pfx_r == PFX_NONE;
  assign REGS = rf_r;

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    st_nxt   = st_r;
    pfx_nxt  = pfx_r;
    rf_nxt   = rf_r;
    ir_nxt   = ir_r;
    ea_nxt   = ea_r;
    hold_nxt = hold_r;
    case (st_r)
      ST_FETCH: begin
        if (LOAD_EN) begin
          rf_nxt = LOAD_REGS;
        end else if (MEM_ACK) begin
          ir_nxt    = MEM_RDATA;
          rf_nxt.pc = pc_inc;
          st_nxt    = ST_DECODE;
        end
      end
      ST_DECODE: begin
        st_nxt  = ST_FETCH;
        pfx_nxt = PFX_NONE;
        if (new_pfx != PFX_NONE) begin
          pfx_nxt = new_pfx;
        end else if (is_tc) begin
          // 80h comes back as 80h by plain subtraction
          rf_nxt.a = tc_res;
          rf_nxt.f = tc_flags(rf_r.f, rf_r.a, tc_res);
        end else if (is_or_mem) begin
          pfx_nxt = pfx_r;
          if (pfx_index) begin
            st_nxt = ST_DISP;
          end else begin
            ea_nxt = ptr_pair;
            st_nxt = ST_MEMRD;
          end
        end else if (is_or) begin
          rf_nxt.a = or_res;
          rf_nxt.f = or_flags(rf_r.f, or_res);
        end else if (is_or_imm) begin
          st_nxt = ST_IMM;
        end else if (is_blk) begin
          // first read the byte at the memory pointer
          pfx_nxt = pfx_r;
          ea_nxt  = ptr_pair;
          st_nxt  = ST_MEMRD;
        end
        // idle and unhandled opcodes touch nothing
      end
      ST_DISP: begin
        if (MEM_ACK) begin
          rf_nxt.pc = pc_inc;
          ea_nxt    = base + disp;
          st_nxt    = ST_MEMRD;
        end
      end
      ST_IMM: begin
        if (MEM_ACK) begin
          rf_nxt.pc = pc_inc;
          rf_nxt.a  = or_res;
          rf_nxt.f  = or_flags(rf_r.f, or_res);
          st_nxt    = ST_FETCH;
        end
      end
      ST_MEMRD: begin
        if (MEM_ACK) begin
          pfx_nxt = PFX_NONE;
          st_nxt  = ST_FETCH;
          if (pfx_ext) begin
            // hold byte, count down before the port cycle
            hold_nxt = MEM_RDATA;
            rf_nxt.b = b_dec;
            st_nxt   = ST_IOWR;
          end else begin
            rf_nxt.a = or_res;
            rf_nxt.f = or_flags(rf_r.f, or_res);
          end
        end
      end
      ST_IOWR: begin
        // A full FIFO holds the whole step here
        if (fifo_in_ready) begin
          {rf_nxt.h, rf_nxt.l} = ptr_moved;
          // zero from count, subtract set, rest kept
          rf_nxt.f[FLG_Z] = rf_r.b == ZERO_BYTE;
          rf_nxt.f[FLG_N] = 1'b1;
          // rewind to the prefix unless count is zero
          if (rf_r.b != ZERO_BYTE) begin
            rf_nxt.pc = rf_r.pc - PC_REWIND;
          end
          st_nxt = ST_FETCH;
        end
      end
      default: begin
        st_nxt  = ST_FETCH;
        pfx_nxt = PFX_NONE;
      end
    endcase
  end

  // state and flags commit together at step end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_r   <= ST_FETCH;
      pfx_r  <= PFX_NONE;
      rf_r   <= REGS_RESET;
      ir_r   <= IDLE_OP;
      hold_r <= ZERO_BYTE;
      ea_r   <= WORD_ZERO;
    end else begin
      st_r   <= st_nxt;
      pfx_r  <= pfx_nxt;
      rf_r   <= rf_nxt;
      ir_r   <= ir_nxt;
      hold_r <= hold_nxt;
      ea_r   <= ea_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output buffer

  // port write cycles queue here for the peripheral side
  nobe_fifo #(
    .WIDTH ($bits(nobe_io_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RST),
    .in_valid  (st_r == ST_IOWR),
    .in_ready  (fifo_in_ready),
    .in_data   (io_push),
    .out_valid (IO_VALID),
    .out_ready (IO_READY),
    .out_data  (IO_WORD)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_tc_step;
    st_r == ST_DECODE && is_tc;
  endsequence

  sequence s_blk_read;
    st_r == ST_MEMRD && MEM_ACK && pfx_ext;
  endsequence

  sequence s_blk_push;
    st_r == ST_IOWR && fifo_in_ready;
  endsequence

  a_tc_value: assert property (
    s_tc_step |=> rf_r.a == ZERO_BYTE - $past(rf_r.a))
    else $error("negation result wrong");

  a_tc_fixed: assert property (
    s_tc_step ##0 rf_r.a == SIGN_BYTE |=> rf_r.a == SIGN_BYTE)
    else $error("negation of 80h changed the accumulator");

  a_tc_flags: assert property (
    s_tc_step |=> rf_r.f[FLG_S] == rf_r.a[7] &&
      rf_r.f[FLG_Z] == (rf_r.a == ZERO_BYTE) &&
      rf_r.f[FLG_H] == ($past(rf_r.a[3:0]) != 4'h0))
    else $error("negation sign, zero or half flag wrong");

  a_tc_pv_carry: assert property (
    s_tc_step |=> rf_r.f[FLG_N] &&
      rf_r.f[FLG_PV] == ($past(rf_r.a) == SIGN_BYTE) &&
      rf_r.f[FLG_C] == ($past(rf_r.a) != ZERO_BYTE))
    else $error("negation overflow, subtract or carry wrong");

  a_idle_flags: assert property (
    st_r == ST_DECODE && pfx_r == PFX_NONE && ir_r == IDLE_OP
      |=> $stable(rf_r.f) && $stable(rf_r.a) && st_r == ST_FETCH)
    else $error("idle opcode changed state");

  a_or_reg: assert property (
    st_r == ST_DECODE && is_or && !is_or_mem
      |=> rf_r.a == ($past(rf_r.a) | $past(reg_val)))
    else $error("register disjunction result wrong");

  a_or_index: assert property (
    st_r == ST_DECODE && is_or_mem && pfx_index
      |=> st_r == ST_DISP ##[1:9] st_r == ST_MEMRD)
    else $error("indexed disjunction skipped displacement");

  a_or_flags: assert property (
    st_r == ST_IMM && MEM_ACK |=> rf_r.f[FLG_PV] == ~^rf_r.a &&
      !rf_r.f[FLG_H] && !rf_r.f[FLG_N] && !rf_r.f[FLG_C] &&
      rf_r.f[FLG_Z] == (rf_r.a == ZERO_BYTE))
    else $error("disjunction flags wrong");

  a_blk_out: assert property (
    s_blk_read |=> st_r == ST_IOWR &&
      rf_r.b == $past(rf_r.b) - BYTE_ONE &&
      io_push.addr == {$past(rf_r.b) - BYTE_ONE, $past(rf_r.c)} &&
      io_push.data == $past(MEM_RDATA))
    else $error("block output cycle wrong");

  a_blk_ptr: assert property (
    s_blk_push |=> ptr_pair == (($past(ir_r) == BLOCK_OUT_DOWN_OP) ?
      $past(ptr_pair) - PTR_STEP : $past(ptr_pair) + PTR_STEP))
    else $error("memory pointer step wrong");

  a_blk_repeat: assert property (
    s_blk_push ##0 rf_r.b != ZERO_BYTE |=> rf_r.pc == $past(rf_r.pc) - PC_REWIND)
    else $error("block output did not rewind");

  a_blk_flags: assert property (
    s_blk_push |=> rf_r.f[FLG_N] && rf_r.f[FLG_Z] == (rf_r.b == ZERO_BYTE) &&
      (rf_r.f & BLK_KEEP_MASK) == ($past(rf_r.f) & BLK_KEEP_MASK))
    else $error("block output flags wrong");

  a_int_gap: assert property (
    INT_ACK |=> st_r == ST_FETCH && pfx_r == PFX_NONE &&
      rf_r.pc == $past(rf_r.pc) - PC_REWIND)
    else $error("interrupt taken outside a repetition gap");

  a_blk_stall: assert property (
    st_r == ST_IOWR && !fifo_in_ready |=> st_r == ST_IOWR && $stable(rf_r))
    else $error("block step moved while buffer full");

endmodule

// *** design/nobe_fifo.sv ***
// Parameterised FIFO that buffers I/O write cycles
`timescale 1ns/100ps
module nobe_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("FIFO depth must be a power of two, two or more");
  end

  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic [WIDTH-1:0] mem_r [DEPTH];

  // Extra pointer bit tells a full ring from an empty one
  wire logic full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire logic empty = wr_r == rd_r;
  wire logic push  = in_valid && !full;
  wire logic pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_r[wr_r[AW-1:0]] <= in_data;
  end

endmodule

// *** include/nobe_pkg.sv ***
// Shared constants and types for the negate/OR/block-output execution unit
package nobe_pkg;

  localparam logic [7:0]  IDLE_OP            = 8'h00;
  localparam logic [7:0]  PFX_EXT_BYTE       = 8'hED;
  localparam logic [7:0]  PFX_FIRST_BYTE     = 8'hDD;
  localparam logic [7:0]  PFX_SECOND_BYTE    = 8'hFD;
  localparam logic [7:0]  TWOS_COMPLEMENT_OP = 8'h44;
  localparam logic [7:0]  BLOCK_OUT_DOWN_OP  = 8'hBB;
  localparam logic [7:0]  BLOCK_OUT_UP_OP    = 8'hB3;
  localparam logic [7:0]  OR_IMM_OP          = 8'hF6;
  localparam logic [4:0]  OR_GROUP           = 5'h16;
  localparam logic [2:0]  SRC_MEM            = 3'h6;

  localparam logic [2:0]  SRC_B = 3'h0;
  localparam logic [2:0]  SRC_C = 3'h1;
  localparam logic [2:0]  SRC_D = 3'h2;
  localparam logic [2:0]  SRC_E = 3'h3;
  localparam logic [2:0]  SRC_H = 3'h4;
  localparam logic [2:0]  SRC_L = 3'h5;

  localparam int FLG_C  = 0;
  localparam int FLG_N  = 1;
  localparam int FLG_PV = 2;
  localparam int FLG_H  = 4;
  localparam int FLG_Z  = 6;
  localparam int FLG_S  = 7;

  localparam logic [7:0]  BLK_KEEP_MASK = 8'hBD;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  SIGN_BYTE     = 8'h80;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [15:0] PTR_STEP      = 16'h0001;
  localparam logic [15:0] PC_REWIND     = 16'h0002;

  localparam int IO_FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'h0,
    ST_DECODE = 3'h1,
    ST_MEMRD  = 3'h3,
    ST_IOWR   = 3'h2,
    ST_DISP   = 3'h6,
    ST_IMM    = 3'h7
  } nobe_state_t;

  typedef enum logic [1:0] {
    PFX_NONE   = 2'h0,
    PFX_EXT    = 2'h1,
    PFX_FIRST  = 2'h2,
    PFX_SECOND = 2'h3
  } nobe_pfx_t;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  h;
    logic [7:0]  l;
    logic [15:0] first_offset_base;
    logic [15:0] second_offset_base;
    logic [15:0] pc;
  } nobe_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } nobe_io_t;

  localparam nobe_regs_t REGS_RESET = '0;

endpackage

// *** tb/nobe_core_tb.sv ***
// Self-checking bench for the negate, OR and block-output execution unit
`timescale 1ns/100ps
module nobe_core_tb;
  import nobe_pkg::*;
  logic        clk;
  logic        rst;
  logic        load_en;
  nobe_regs_t  load_regs;
  logic        mem_req;
  logic [15:0] mem_addr;
  logic        mem_ack;
  logic [7:0]  mem_rdata;
  logic        io_valid;
  logic        io_ready;
  nobe_io_t    io_word;
  logic        int_req;
  logic        int_ack;
  logic        boundary;
  nobe_regs_t  regs;
  logic        slow;
  logic        io_stall;
  int          num_errors;
  int          check_count;
  int          int_acks;
  nobe_core dut_u (
    .SYS_CLK(clk), .RST(rst), .LOAD_EN(load_en), .LOAD_REGS(load_regs),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .IO_VALID(io_valid), .IO_READY(io_ready),
    .IO_WORD(io_word), .INT_REQ(int_req), .INT_ACK(int_ack),
    .INSTR_BOUNDARY(boundary), .REGS(regs)
  );
  nobe_mem_model mem_u (
    .clk(clk), .rst(rst), .slow(slow), .io_stall(io_stall),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .io_valid(io_valid), .io_ready(io_ready),
    .io_word(io_word)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (int_ack === 1'b1) int_acks++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic nobe_regs_t mk(input logic [7:0] a, input logic [7:0] f);
    return '{a:a, f:f, b:8'h01, c:8'h02, d:8'h04, e:8'h08, h:8'h40, l:8'h10,
             first_offset_base:16'h5000, second_offset_base:16'h6000, pc:16'h0100};
  endfunction
  task automatic prog(input logic [23:0] code);
    mem_u.mem[16'h0100] = code[23:16];
    mem_u.mem[16'h0101] = code[15:8];
    mem_u.mem[16'h0102] = code[7:0];
    mem_u.mem[16'h0103] = IDLE_OP;
  endtask
  // Preload only lands in fetch state, so hold it long enough to cover a slow fetch
  task automatic run(input nobe_regs_t r, input logic [15:0] stop);
    int n;
    @(posedge clk);
    load_en <= 1'b1;
    load_regs <= r;
    repeat (8) @(posedge clk);
    load_en <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(boundary === 1'b1 && regs.pc === stop) && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_tc();
    logic [7:0] v [5];
    logic [7:0] q;
    logic [7:0] f0;
    v = '{8'h00, 8'h01, 8'h80, 8'h10, 8'hFF};
    for (int i = 0; i < 5; i++) begin
      f0 = i[0] ? 8'hD7 : 8'h28;
      q = 8'h00 - v[i];
      prog({PFX_EXT_BYTE, TWOS_COMPLEMENT_OP, 8'h00});
      run(mk(v[i], f0), 16'h0102);
      chk_byte("negate a", q, regs.a);
      chk_byte("negate f", {q[7], q == 8'h00, f0[5], v[i][3:0] != 4'h0, f0[3],
                         v[i] == 8'h80, 1'b1, v[i] != 8'h00}, regs.f);
    end
  endtask
  task automatic t_idle();
    prog(24'h000000);
    run(mk(8'h5A, 8'hFF), 16'h0101);
    chk_byte("idle a", 8'h5A, regs.a);
    chk_byte("idle f", 8'hFF, regs.f);
  endtask
  task automatic or_case(input logic [23:0] code, input logic [15:0] stop,
                         input logic [7:0] a, input logic [7:0] src);
    logic [7:0] e;
    prog(code);
    run(mk(a, 8'hFF), stop);
    e = a | src;
    chk_byte("or a", e, regs.a);
    chk_byte("or f", {e[7], e == 8'h00, 1'b1, 1'b0, 1'b1, ~^e, 2'b00}, regs.f);
  endtask
  task automatic t_or();
    logic [7:0] s [7];
    s = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h10, 8'hA3};
    for (int i = 0; i < 7; i++) begin
      or_case({8'hB0 | 8'(i < 6 ? i : 7), 16'h0000}, 16'h0101, 8'hA3, s[i]);
    end
    or_case({OR_IMM_OP, 16'h0C00}, 16'h0102, 8'hA3, 8'h0C);
    or_case(24'hB60000, 16'h0101, 8'h20, 8'h4A);
    or_case({PFX_FIRST_BYTE, 16'hB605}, 16'h0103, 8'h0C, 8'h81);
    or_case({PFX_SECOND_BYTE, 16'hB6FE}, 16'h0103, 8'h00, 8'h00);
  endtask
  // Fill case holds the port stalled for 400 cycles, by which time the buffer refuses a seventeenth word
  task automatic t_blk(input logic [7:0] op, input logic [7:0] cnt,
                       input logic sl, input logic irq, input logic fill);
    nobe_regs_t  r;
    logic [15:0] ptr;
    logic        up;
    up = (op == BLOCK_OUT_UP_OP);
    r = mk(8'h00, 8'hA5);
    r.b = cnt;
    prog({PFX_EXT_BYTE, op, 8'h00});
    mem_u.got.delete();
    int_acks = 0;
    @(posedge clk);
    slow <= sl;
    int_req <= irq;
    io_stall <= fill;
    fork
      run(r, 16'h0102);
      if (fill) begin
        repeat (400) @(posedge clk);
        #1;
        chk_word("held pointer", 24'h004020, {8'h00, regs.h, regs.l});
        chk_byte("held words", 8'h00, 8'(mem_u.got.size()));
        chk_byte("full valid", 8'h01, {7'h00, io_valid});
        io_stall <= 1'b0;
      end
    join
    repeat (24) @(posedge clk);
    #1;
    ptr = up ? 16'h4010 + cnt : 16'h4010 - cnt;
    chk_byte("count", 8'h00, regs.b);
    chk_word("pointer", {8'h00, ptr}, {8'h00, regs.h, regs.l});
    chk_byte("blk f", 8'hE7, regs.f);
    chk_byte("int acks", irq ? cnt - 8'h01 : 8'h00, 8'(int_acks));
    chk_byte("words", cnt, 8'(mem_u.got.size()));
    for (int i = 0; i < mem_u.got.size(); i++) begin
      ptr = up ? 16'h4010 + 16'(i) : 16'h4010 - 16'(i);
      chk_word("io word", {cnt - 8'(i + 1), 8'h02, ptr[7:0] ^ 8'h5A},
               mem_u.got[i]);
    end
    @(posedge clk);
    int_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    load_en = 1'b0;
    load_regs = REGS_RESET;
    int_req = 1'b0;
    slow = 1'b0;
    io_stall = 1'b0;
    num_errors = 0;
    check_count = 0;
    int_acks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 16'h3FE0; i < 16'h4060; i++) mem_u.mem[i] = i[7:0] ^ 8'h5A;
    mem_u.mem[16'h5005] = 8'h81;
    t_tc();
    t_idle();
    t_or();
    t_blk(BLOCK_OUT_DOWN_OP, 8'h03, 1'b1, 1'b0, 1'b0);
    t_blk(BLOCK_OUT_UP_OP, 8'h02, 1'b0, 1'b1, 1'b0);
    t_blk(BLOCK_OUT_UP_OP, 8'h11, 1'b0, 1'b0, 1'b1);
    conclude();
  end
endmodule

// *** tb/nobe_mem_model.sv ***
// Memory and I/O port partner model for the execution unit
`timescale 1ns/100ps
module nobe_mem_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               slow,
  input  wire logic               io_stall,
  input  wire logic               mem_req,
  input  wire logic [15:0]        mem_addr,
  output logic                    mem_ack,
  output logic [7:0]              mem_rdata,
  input  wire logic               io_valid,
  output logic                    io_ready,
  input  wire nobe_pkg::nobe_io_t io_word
);
  import nobe_pkg::*;
  logic [7:0] mem [0:65535];
  logic [1:0] wait_r;
  nobe_io_t   got [$];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Idle data bus toggles, so a stale byte can never pass for a read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      wait_r <= 2'h0;
      io_ready <= 1'b0;
    end else begin
      io_ready <= !io_stall;
      if (io_valid && io_ready) got.push_back(io_word);
      if (mem_ack) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end else if (mem_req && wait_r == 2'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr];
        wait_r <= slow ? 2'h2 : 2'h0;
      end else begin
        mem_rdata <= ~mem_rdata;
        if (mem_req) wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule
